// ===== hw/pssr_pkg.sv
// Package for the power-switch state register bank: offsets, fields,
// reset values and rail state codes.
// Assumes a register port with 8-bit address and 8-bit data.
`default_nettype none

package pssr_pkg;

	localparam int PSSR_NUM_RAILS = 3;
	localparam logic [7:0] PSSR_ADDR_RADIO = 8'h4e;
	localparam logic [7:0] PSSR_ADDR_PANEL = 8'h4f;
	localparam logic [7:0] PSSR_ADDR_GENERAL = 8'h50;
	localparam logic [7:0] PSSR_RESET_VALUE = 8'h24;
	localparam int PSSR_STATE_LSB = 0;
	localparam int PSSR_EXIT_LSB = 3;
	localparam logic [1:0] PSSR_RESERVED_READ = 2'h0;

	typedef enum logic [2:0] {
		PSSR_CODE_OFF = 3'h4,
		PSSR_CODE_LOW_POWER = 3'h5,
		PSSR_CODE_ACTIVE_A = 3'h6,
		PSSR_CODE_ACTIVE_B = 3'h7
	} pssr_code_e;

	typedef enum logic [1:0] {
		PSSR_RAIL_RESERVED = 2'h0,
		PSSR_RAIL_OFF = 2'h1,
		PSSR_RAIL_LOW_POWER = 2'h2,
		PSSR_RAIL_ACTIVE = 2'h3
	} pssr_rail_e;

	// One rail's stored fields
	typedef struct packed {
		logic [2:0] exit_state;
		logic [2:0] state_select;
	} pssr_rail_s;

	// Register access request
	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pssr_req_s;

endpackage

`default_nettype wire

// ===== hw/pssr_bank.sv
// Switch control register bank for the three 3.3 V power-switch rails.
// Assumes a same-clock register port driven by the SPI controller and an
// asynchronous standby-exit pin.
// Operation
// - Three RW registers, reset 0x24
// - Bits 2:0 decode rail state
// - Standby exit copies codes 4-7
// - Codes 0-3 in exit field: no copy
`default_nettype none

module pssr_bank
	import pssr_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire pssr_req_s req,
	input wire logic standby_exit_pin,
	output logic [7:0] rdata,
	output logic rd_valid,
	output logic addr_hit,
	output pssr_rail_e radio_gps_rail_switch,
	output pssr_rail_e panel_rail_switch,
	output pssr_rail_e general_rail_switch
);

	// ****************************************
	// Constants
	// ****************************************
	// Index that no register owns
	localparam logic [1:0] IDX_NONE = 2'h3;
	localparam pssr_rail_s RAIL_RESET = pssr_rail_s'(PSSR_RESET_VALUE[5:0]);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [1:0] rail_index(input logic [7:0] a);
		unique case (a)
			PSSR_ADDR_RADIO: rail_index = 2'h0;
			PSSR_ADDR_PANEL: rail_index = 2'h1;
			PSSR_ADDR_GENERAL: rail_index = 2'h2;
			default: rail_index = IDX_NONE;
		endcase
	endfunction

	function automatic pssr_rail_e decode_state(input logic [2:0] c);
		unique case (c)
			PSSR_CODE_OFF: decode_state = PSSR_RAIL_OFF;
			PSSR_CODE_LOW_POWER: decode_state = PSSR_RAIL_LOW_POWER;
			PSSR_CODE_ACTIVE_A,
			PSSR_CODE_ACTIVE_B: decode_state = PSSR_RAIL_ACTIVE;
			default: decode_state = PSSR_RAIL_RESERVED;
		endcase
	endfunction

	// Exit codes 0-3 leave the rail alone
	function automatic logic exit_code_copies(input logic [2:0] c);
		exit_code_copies = c[2];
	endfunction

	function automatic logic index_mapped(input logic [1:0] idx);
		index_mapped = (idx != IDX_NONE);
	endfunction

	// ****************************************
	// Standby-exit pin synchroniser and edge
	// ****************************************
	logic exit_meta_reg;
	logic exit_sync_reg;
	logic exit_prev_reg;
	logic exit_rise;

	// Two flops before any logic sees the pin
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			exit_meta_reg <= 1'b0;
			exit_sync_reg <= 1'b0;
		end
		else
		begin
			exit_meta_reg <= standby_exit_pin;
			exit_sync_reg <= exit_meta_reg;
		end
	end

	// Resets to the idle pin level, so reset alone makes no edge
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			exit_prev_reg <= 1'b0;
		end
		else
		begin
			exit_prev_reg <= exit_sync_reg;
		end
	end

	// Copy once per assertion, not every cycle it stays high
	assign exit_rise = exit_sync_reg & ~exit_prev_reg;

	// ****************************************
	// Address decode
	// ****************************************
	logic [1:0] wr_idx;
	logic acc_mapped;

	assign wr_idx = rail_index(req.addr);
	assign acc_mapped = index_mapped(wr_idx);

	// ****************************************
	// Register array
	// ****************************************
	pssr_rail_s rail_reg [PSSR_NUM_RAILS];

	for (genvar i = 0; i < PSSR_NUM_RAILS; i++)
	begin : g_rail
		logic wr_hit;
		logic copy_hit;

		assign wr_hit = req.wr_en && (wr_idx == 2'(i));
		assign copy_hit = exit_rise &&
			exit_code_copies(rail_reg[i].exit_state);

		always_ff @(posedge mclk or posedge rst)
		begin
			if (rst)
			begin
				rail_reg[i] <= RAIL_RESET;
			end
			else
			begin
				// Bits 7:6 have no storage, so writes there vanish
				if (wr_hit)
				begin
					rail_reg[i].exit_state <= req.wdata[PSSR_EXIT_LSB +: 3];
					rail_reg[i].state_select <= req.wdata[PSSR_STATE_LSB +: 3];
				end
				// Exit copy wins over a same-cycle write of the state field
				if (copy_hit)
					rail_reg[i].state_select <= rail_reg[i].exit_state;
			end
		end
	end

	// ****************************************
	// Read port
	// ****************************************
	// Both echoes follow one cycle late for as long as the strobe stays high; addr_hit rises only for a mapped address
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			rd_valid <= 1'b0;
		end
		else
		begin
			rd_valid <= req.rd_en;
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			addr_hit <= 1'b0;
		end
		else
		begin
			addr_hit <= (req.rd_en || req.wr_en) && acc_mapped;
		end
	end

	// Holds the last read value; unmapped reads return zero
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			rdata <= 8'h00;
		end
		else if (req.rd_en)
		begin
			if (acc_mapped)
				rdata <= {PSSR_RESERVED_READ, rail_reg[wr_idx]};
			else
				rdata <= 8'h00;
		end
	end

	// ****************************************
	// Rail state outputs
	// ****************************************
	// One cycle behind the register, traded for flop-driven outputs
	localparam pssr_rail_e RAIL_OUT_RESET =
		decode_state(PSSR_RESET_VALUE[PSSR_STATE_LSB +: 3]);

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			radio_gps_rail_switch <= RAIL_OUT_RESET;
		end
		else
		begin
			radio_gps_rail_switch <= decode_state(rail_reg[0].state_select);
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			panel_rail_switch <= RAIL_OUT_RESET;
		end
		else
		begin
			panel_rail_switch <= decode_state(rail_reg[1].state_select);
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			general_rail_switch <= RAIL_OUT_RESET;
		end
		else
		begin
			general_rail_switch <= decode_state(rail_reg[2].state_select);
		end
	end

endmodule

`default_nettype wire

// ===== testbench/pssr_checker.sv
// Port checks on the bank; the bench binds this to pssr_bank.
`default_nettype none
module pssr_checker import pssr_pkg::*; (
	input wire logic mclk,
	input wire logic rst,
	input wire pssr_req_s req,
	input wire logic [7:0] rdata,
	input wire logic rd_valid,
	input wire logic addr_hit,
	input wire logic [1:0] panel_rail_switch
);
	timeunit 1ns / 1ns;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_valid_pulse: assert property (req.rd_en |=> rd_valid)
		else $error("no valid");
	a_valid_quiet: assert property (!req.rd_en |=> !rd_valid)
		else $error("stray valid");
	a_reset_off: assert property ($fell(rst) |->
		panel_rail_switch == PSSR_RAIL_OFF) else $error("rail on");
	a_hit_mapped: assert property ((req.rd_en || req.wr_en) &&
		req.addr inside {[8'h4e:8'h50]} |=> addr_hit) else $error("no hit");
	a_miss_quiet: assert property (req.rd_en &&
		!(req.addr inside {[8'h4e:8'h50]}) |=> !addr_hit && rdata == 8'h00)
		else $error("miss");
	a_reserved_zero: assert property (req.rd_en |=>
		rdata[7:6] == PSSR_RESERVED_READ) else $error("rsvd");
	a_state_decode: assert property (req.wr_en &&
		req.addr == PSSR_ADDR_PANEL && req.wdata[2:0] == 3'h5 ##1 !req.wr_en
		|=> panel_rail_switch == PSSR_RAIL_LOW_POWER) else $error("decode");
endmodule
`default_nettype wire

// ===== testbench/pssr_host.sv
// SPI host model; strobes last one cycle, set on falling edges.
`default_nettype none
module pssr_host import pssr_pkg::*; (
	input wire logic mclk,
	output var pssr_req_s req
);
	timeunit 1ns / 1ns;
	initial req = '0;
	task acc(logic w, logic [7:0] a, d);
		@(negedge mclk);
		req = {w, !w, a, d};
		@(negedge mclk);
		req = '0;
	endtask
endmodule
`default_nettype wire

// ===== testbench/test_pssr_bank.sv
// Bench: reset, access, standby exit; the host model owns the port.
`default_nettype none
module test_pssr_bank
	import pssr_pkg::*;
();
	timeunit 1ns / 1ns;
	logic mclk = 0, rst = 1, pin = 0;
	logic [7:0] rdata;
	pssr_rail_e r0, r1, r2;
	pssr_req_s req;
	int n_mismatch = 0, check_count = 0, cyc = 0;
	always #5 mclk = ~mclk;
	pssr_host host (.mclk(mclk), .req(req));
	pssr_bank uut (.mclk(mclk), .rst(rst), .req(req), .rdata(rdata),
		.standby_exit_pin(pin), .rd_valid(), .addr_hit(),
		.radio_gps_rail_switch(r0), .panel_rail_switch(r1),
		.general_rail_switch(r2));
	task chk(string n, logic [7:0] s, e);
		check_count++;
		if (s !== e)
			$display("ERROR %s exp %h got %h", n, e, s);
		n_mismatch += (s !== e);
	endtask
	task rd(string n, logic [7:0] a, e);
		host.acc(0, a, 8'h00);
		@(negedge mclk);
		chk(n, rdata, e);
	endtask
	task test_done;
		n_mismatch += (cyc >= 500);
		if (n_mismatch == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge mclk) if (++cyc == 500) test_done;
	initial
	begin
		repeat (16) @(negedge mclk);
		rst = 0;
		for (int i = 0; i < 3; i++) rd("reset", 8'h4e + 8'(i), 8'h24);
		host.acc(1, 8'h4e, 8'hf5);
		host.acc(1, 8'h4f, 8'h15);
		host.acc(1, 8'h50, 8'h3c);
		rd("resv", 8'h4e, 8'h35);
		host.acc(1, 8'h4d, 8'h3f);
		rd("gen", 8'h50, 8'h3c);
		rd("unmap", 8'h51, 8'h00);
		chk("general", 8'(r2), 8'(PSSR_RAIL_OFF));
		pin = 1;
		repeat (5) @(negedge mclk);
		chk("radio", 8'(r0), 8'(PSSR_RAIL_ACTIVE));
		chk("general", 8'(r2), 8'(PSSR_RAIL_ACTIVE));
		chk("panel", 8'(r1), 8'(PSSR_RAIL_LOW_POWER));
		host.acc(1, 8'h4e, 8'h33);
		repeat (3) @(negedge mclk);
		chk("rsvd code", 8'(r0), 8'(PSSR_RAIL_RESERVED));
		rd("held", 8'h4e, 8'h33);
		pin = 0;
		repeat (3) @(negedge mclk);
		pin = 1;
		repeat (5) @(negedge mclk);
		chk("recopy", 8'(r0), 8'(PSSR_RAIL_ACTIVE));
		rd("recopy rd", 8'h4e, 8'h36);
		chk("panel 2", 8'(r1), 8'(PSSR_RAIL_LOW_POWER));
		pin = 0;
		rst = 1;
		repeat (2) @(negedge mclk);
		rst = 0;
		chk("rst panel", 8'(r1), 8'(PSSR_RAIL_OFF));
		rd("rst radio", 8'h4e, 8'h24);
		test_done;
	end
endmodule
bind pssr_bank pssr_checker chk_i (.mclk(mclk), .rst(rst), .req(req),
	.rdata(rdata), .rd_valid(rd_valid), .addr_hit(addr_hit),
	.panel_rail_switch(panel_rail_switch));
`default_nettype wire
